// file: rtl/timer_channel_mode_control.sv
/*
  Mode register and decode for one timer channel: register storage,
  input edge detection, start/capture trigger selection, count clock
  selection, start interrupt and output toggle, retrigger handling.
  Assumes all inputs synchronous to mclk_in, and a prescaler outside
  that gives a one-cycle tick of the selected operation clock.
*/
// Behaviour
// - on channel 2, bit 11 set makes the channel a master.
// - only channel 2 can become master through bit 11.
// - channel 0 is always master; its bit 11 reads zero.
// - on channels 1 and 3, bit 11 selects 8-bit split operation.
// - trigger field picks software, edge, both edges or master start.
// - edge field picks falling, rising, low or high width edges.
// - mode field sets operating mode and count direction.
// - interval and capture: option bit raises interrupt and toggle.
// - event counter start raises no interrupt, output unchanged.
// - one-count, option 0: starts during counting are ignored.
// - one-count, option 1: start during counting restarts, no interrupt.
// - one-count start never drives interrupt or output.
// - capture one-count: no start interrupt, busy starts ignored.
// - count clock is operation clock tick or valid input edge.
// - mode register clears to zero on reset.
`timescale 1ns/1ps
module timer_channel_mode_control #(
  parameter int CHANNEL = 0
) (
  input  wire logic                      mclk_in,
  input  wire logic                      arst_n_in,
  input  wire timer_mode_pkg::reg_req_t  reg_req_in,
  output      logic [15:0]               reg_rdata_out,
  input  wire logic                      op_clock_tick_in,
  input  wire logic                      timer_input_pin_in,
  input  wire logic                      channel_start_trigger_in,
  input  wire logic                      channel_stop_trigger_in,
  input  wire logic                      master_interrupt_in,
  input  wire logic                      count_done_in,
  output      timer_mode_pkg::chan_ctrl_t ctrl_out,
  output      logic [1:0]                operation_clock_select_out,
  output      logic                      master_role_select_out,
  output      logic                      width_split_select_out
);
  import timer_mode_pkg::*;

  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_COUNT = 1'b1
  } chan_state_t;

  // field view of the raw register, used by decode and status
  function automatic mode_fields_t fields_of(input logic [15:0] r);
    mode_fields_t f;
    f.op_clock  = r[OPCLK_MSB:OPCLK_LSB];
    f.clk_src   = r[CLKSRC_BIT];
    f.role      = r[ROLE_BIT];
    f.trig      = r[TRIG_MSB:TRIG_LSB];
    f.edge_sel  = r[EDGE_MSB:EDGE_LSB];
    f.opmode    = r[OPMODE_MSB:OPMODE_LSB];
    f.start_opt = r[STARTOPT_BIT];
    return f;
  endfunction : fields_of

  function automatic logic mode_legal(input logic [2:0] m);
    return (m == OPM_INTERVAL) || (m == OPM_CAPTURE) ||
           (m == OPM_EVENT) || (m == OPM_ONE_COUNT) ||
           (m == OPM_CAPTURE_ONE);
  endfunction : mode_legal

  function automatic logic trig_legal(input logic [2:0] t);
    return (t == TRIG_SOFTWARE) || (t == TRIG_EDGE) ||
           (t == TRIG_BOTH) || (t == TRIG_MASTER);
  endfunction : trig_legal

  logic [15:0]  mode_reg;
  logic [15:0]  next_mode_reg;
  logic         pin_q;
  logic         next_pin_q;
  logic [15:0]  next_rdata;
  chan_state_t  state;
  chan_state_t  next_state;
  chan_ctrl_t   next_ctrl;
  mode_fields_t f;
  logic         rise;
  logic         fall;
  logic         valid_edge;
  logic         start_edge;
  logic         capture_edge;
  logic         trig_start;
  logic         trig_capture;
  logic         bad_config;
  logic         busy_block;
  logic [15:0]  role_mask;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!arst_n_in);

  assign f = fields_of(mode_reg);

  // bit 11 only stores where the channel has a role or split bit
  // role bit gate
  assign role_mask = (CHANNEL == 0 || CHANNEL > 3) ? 16'hf7ff : 16'hffff;

  // register write path; reserved bits masked so they read zero
  always_comb begin
    next_mode_reg = mode_reg;
    if (reg_req_in.wr && reg_req_in.addr == MODE_REG_OFFSET) begin
      next_mode_reg = reg_req_in.wdata & MODE_WRITE_MASK & role_mask;
    end
  end

  // read data stands one cycle after the read strobe only
  always_comb begin
    next_rdata = 16'h0000;
    if (reg_req_in.rd) begin
      unique case (reg_req_in.addr)
        MODE_REG_OFFSET:   next_rdata = mode_reg;
        STATUS_REG_OFFSET: next_rdata = {12'h000, ~trig_legal(f.trig),
                                         ~mode_legal(f.opmode), pin_q,
                                         (state == ST_COUNT)};
        default:           next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_reg      <= MODE_RESET;
      reg_rdata_out <= 16'h0000;
    end else begin
      mode_reg      <= next_mode_reg;
      reg_rdata_out <= next_rdata;
    end
  end

  assign master_role_select_out = (CHANNEL == 0) ||
                                  (CHANNEL == 2 && f.role);
  assign width_split_select_out = (CHANNEL == 1 || CHANNEL == 3) && f.role;
  assign operation_clock_select_out = f.op_clock;

  // pin sampled on operation clock tick
  always_comb begin
    next_pin_q = pin_q;
    if (op_clock_tick_in) begin
      next_pin_q = timer_input_pin_in;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= next_pin_q;
    end
  end

  // edge pulses last only the tick cycle, so one per transition
  assign rise = op_clock_tick_in && timer_input_pin_in && !pin_q;
  assign fall = op_clock_tick_in && !timer_input_pin_in && pin_q;

  always_comb begin
    unique case (f.edge_sel)
      EDGE_FALL: begin
        valid_edge   = fall;
        start_edge   = fall;
        capture_edge = fall;
      end
      EDGE_RISE: begin
        valid_edge   = rise;
        start_edge   = rise;
        capture_edge = rise;
      end
      EDGE_LOW_WIDTH: begin
        valid_edge   = rise || fall;
        start_edge   = fall;
        capture_edge = rise;
      end
      EDGE_HIGH_WIDTH: begin
        valid_edge   = rise || fall;
        start_edge   = rise;
        capture_edge = fall;
      end
    endcase
  end

  // trigger source selection; prohibited codes give only the software start, no capture
  always_comb begin
    trig_start   = channel_start_trigger_in;
    trig_capture = 1'b0;
    unique case (f.trig)
      TRIG_SOFTWARE: ;
      TRIG_EDGE: begin
        trig_start   = channel_start_trigger_in || valid_edge;
        trig_capture = valid_edge;
      end
      TRIG_BOTH: begin
        trig_start   = channel_start_trigger_in || start_edge;
        trig_capture = capture_edge;
      end
      TRIG_MASTER: begin
        trig_start = channel_start_trigger_in || master_interrupt_in;
      end
      default: trig_start = channel_start_trigger_in;
    endcase
  end

  // prohibited codes hold the channel idle
  assign bad_config = !mode_legal(f.opmode) || !trig_legal(f.trig);

  // one-count option 0 ignores busy starts
  assign busy_block = (f.opmode == OPM_ONE_COUNT && !f.start_opt) ||
                      (f.opmode == OPM_CAPTURE_ONE);

  // run state and registered control pulses
  always_comb begin
    next_state = state;
    next_ctrl  = '0;
    next_ctrl.count_up = (f.opmode == OPM_CAPTURE) ||
                         (f.opmode == OPM_CAPTURE_ONE);
    unique case (state)
      ST_IDLE: begin
        if (trig_start && !bad_config && !channel_stop_trigger_in) begin
          next_state      = ST_COUNT;
          next_ctrl.start = 1'b1;
          if ((f.opmode == OPM_INTERVAL || f.opmode == OPM_CAPTURE) &&
              f.start_opt) begin
            next_ctrl.start_irq  = 1'b1;
            next_ctrl.out_toggle = 1'b1;
          end
        end
      end
      ST_COUNT: begin
        if (channel_stop_trigger_in || bad_config) begin
          next_state = ST_IDLE;
        end else if (trig_start && !busy_block) begin
          next_ctrl.start = 1'b1;
        end else if (count_done_in && (f.opmode == OPM_ONE_COUNT ||
                                       f.opmode == OPM_CAPTURE_ONE)) begin
          next_state = ST_IDLE;
        end
        next_ctrl.count_tick = f.clk_src ? valid_edge : op_clock_tick_in;
        next_ctrl.capture = trig_capture &&
                            (f.opmode == OPM_CAPTURE ||
                             f.opmode == OPM_CAPTURE_ONE);
      end
    endcase
    next_ctrl.counting = (next_state == ST_COUNT);
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state    <= ST_IDLE;
      ctrl_out <= '0;
    end else begin
      state    <= next_state;
      ctrl_out <= next_ctrl;
    end
  end

  a_reserved_read_zero: assert property (
    mode_reg[13] == 1'b0 && mode_reg[5] == 1'b0 && mode_reg[4] == 1'b0)
    else $error("reserved mode bits not zero");

  a_ch0_role_fixed: assert property (
    (CHANNEL == 0) |-> (!mode_reg[ROLE_BIT] && master_role_select_out))
    else $error("channel zero role bit stored");

  a_master_follows: assert property (
    (CHANNEL == 2 && reg_req_in.wr && reg_req_in.addr == MODE_REG_OFFSET)
    |=> master_role_select_out == $past(reg_req_in.wdata[ROLE_BIT]))
    else $error("master role not taken from write");

  a_split_follows: assert property (
    (reg_req_in.wr && reg_req_in.addr == MODE_REG_OFFSET)
    |=> width_split_select_out ==
        ((CHANNEL == 1 || CHANNEL == 3) &&
         $past(reg_req_in.wdata[ROLE_BIT])))
    else $error("split select wrong");

  a_oneshot_ignore_busy: assert property (
    (state == ST_COUNT && f.opmode == OPM_ONE_COUNT && !f.start_opt &&
     trig_start) |=> !ctrl_out.start)
    else $error("busy start accepted in one-count");

  a_oneshot_restart: assert property (
    (state == ST_COUNT && f.opmode == OPM_ONE_COUNT && f.start_opt &&
     trig_start && !channel_stop_trigger_in && !bad_config)
    |=> ctrl_out.start && !ctrl_out.start_irq && ctrl_out.counting)
    else $error("one-count restart wrong");

  a_start_irq_pair: assert property (
    (state == ST_IDLE && trig_start && !channel_stop_trigger_in &&
     f.opmode == OPM_INTERVAL && f.start_opt && trig_legal(f.trig))
    |=> ctrl_out.start_irq && ctrl_out.out_toggle ##1 !ctrl_out.start_irq)
    else $error("start interrupt missing");

  a_start_irq_modes: assert property (
    ctrl_out.start_irq |-> ($past(f.opmode) == OPM_INTERVAL ||
                            $past(f.opmode) == OPM_CAPTURE))
    else $error("start interrupt in silent mode");

  a_prohibited_idle: assert property (
    bad_config |=> !ctrl_out.start && !ctrl_out.counting)
    else $error("prohibited code started count");

  a_edge_single: assert property (
    rise |=> !rise)
    else $error("edge pulse longer than a cycle");

  a_count_src_tick: assert property (
    (state == ST_COUNT && next_state == ST_COUNT && !f.clk_src &&
     op_clock_tick_in) |=> ctrl_out.count_tick)
    else $error("count tick missing");

  a_count_src_edge: assert property (
    (state == ST_COUNT && next_state == ST_COUNT && f.clk_src)
    |=> ctrl_out.count_tick == $past(valid_edge))
    else $error("edge count tick wrong");

endmodule : timer_channel_mode_control

// file: rtl/timer_mode_pkg.sv
/*
  Shared constants and carriers for the timer channel mode block:
  register offsets, field positions, reset value, field codes, structs.
  Assumes a 16-bit register port and one 50 MHz clock.
*/
package timer_mode_pkg;

  localparam int          ADDR_W            = 4;
  localparam int          DATA_W            = 16;

  // register offsets on the plain register port
  localparam logic [3:0]  MODE_REG_OFFSET   = 4'h0;
  localparam logic [3:0]  STATUS_REG_OFFSET = 4'h1;

  // field positions inside the channel mode register
  localparam int          OPCLK_MSB         = 15;
  localparam int          OPCLK_LSB         = 14;
  localparam int          CLKSRC_BIT        = 12;
  localparam int          ROLE_BIT          = 11;
  localparam int          TRIG_MSB          = 10;
  localparam int          TRIG_LSB          = 8;
  localparam int          EDGE_MSB          = 7;
  localparam int          EDGE_LSB          = 6;
  localparam int          OPMODE_MSB        = 3;
  localparam int          OPMODE_LSB        = 1;
  localparam int          STARTOPT_BIT      = 0;

  localparam logic [15:0] MODE_RESET        = 16'h0000;
  // bits 13, 5 and 4 never store
  localparam logic [15:0] MODE_WRITE_MASK   = 16'hdfcf;

  // trigger source codes
  localparam logic [2:0]  TRIG_SOFTWARE     = 3'h0;
  localparam logic [2:0]  TRIG_EDGE         = 3'h1;
  localparam logic [2:0]  TRIG_BOTH         = 3'h2;
  localparam logic [2:0]  TRIG_MASTER       = 3'h4;

  // input edge codes
  localparam logic [1:0]  EDGE_FALL         = 2'h0;
  localparam logic [1:0]  EDGE_RISE         = 2'h1;
  localparam logic [1:0]  EDGE_LOW_WIDTH    = 2'h2;
  localparam logic [1:0]  EDGE_HIGH_WIDTH   = 2'h3;

  // operating mode codes
  localparam logic [2:0]  OPM_INTERVAL      = 3'h0;
  localparam logic [2:0]  OPM_CAPTURE       = 3'h2;
  localparam logic [2:0]  OPM_EVENT         = 3'h3;
  localparam logic [2:0]  OPM_ONE_COUNT     = 3'h4;
  localparam logic [2:0]  OPM_CAPTURE_ONE   = 3'h6;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic [1:0] op_clock;
    logic       clk_src;
    logic       role;
    logic [2:0] trig;
    logic [1:0] edge_sel;
    logic [2:0] opmode;
    logic       start_opt;
  } mode_fields_t;

  typedef struct packed {
    logic start;
    logic capture;
    logic count_tick;
    logic count_up;
    logic start_irq;
    logic out_toggle;
    logic counting;
  } chan_ctrl_t;

endpackage : timer_mode_pkg

// file: dv/pin_source_model.sv
/*
  Far-side model: the timer input pin and the prescaled operation clock
  tick. Assumes one clock shared with the block; the pin moves only
  right after a clock edge, and only when the bench asks.
*/
`timescale 1ns/1ps
module pin_source_model #(
  parameter int TICK_DIV = 4
) (
  input  wire logic mclk_in,
  input  wire logic arst_n_in,
  input  wire logic flip_in,
  output      logic pin_out,
  output      logic tick_out
);
  int cnt;

  // slow tick so a pin edge must wait to be seen, as on real prescalers
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt      <= 0;
      tick_out <= 1'b0;
      pin_out  <= 1'b0;
    end else begin
      cnt      <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
      tick_out <= (cnt == TICK_DIV - 1);
      if (flip_in) pin_out <= ~pin_out; // level flips on request only
    end
  end
endmodule : pin_source_model

// file: dv/tb_timer_channel_mode_control.sv
/*
  Self-checking bench for the timer channel mode block, channel 2.
  Assumes the package and the pin source model are compiled first.
*/
`timescale 1ns/1ps
module tb_timer_channel_mode_control;
  import timer_mode_pkg::*;
  logic        mclk_in   = 1'b0;
  logic        arst_n_in = 1'b1;
  reg_req_t    req       = '0;
  logic        flip = 1'b0, sw_start = 1'b0, stop = 1'b0, m_irq = 1'b0;
  logic        tick, pin, role, split, up, irq;
  logic        rd_d = 1'b0;
  logic [15:0] rdata;
  logic [1:0]  opclk;
  chan_ctrl_t  ctrl;
  logic [15:0] rq[$];
  logic [2:0]  sq[$];
  logic [2:0]  cq[$];
  int          fails = 0;
  int          checks_done = 0;
  logic [3:0]  modes [8] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hc};
  logic [4:0]  et [4] = '{5'h04, 5'h05, 5'h06, 5'h0b};

  initial forever #10 mclk_in = ~mclk_in;

  pin_source_model u_pin (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .flip_in(flip), .pin_out(pin), .tick_out(tick));

  timer_channel_mode_control #(.CHANNEL(2)) u_dut (.mclk_in(mclk_in),
    .arst_n_in(arst_n_in), .reg_req_in(req), .reg_rdata_out(rdata),
    .op_clock_tick_in(tick), .timer_input_pin_in(pin),
    .channel_start_trigger_in(sw_start), .channel_stop_trigger_in(stop),
    .master_interrupt_in(m_irq), .count_done_in(1'b0), .ctrl_out(ctrl),
    .operation_clock_select_out(opclk), .master_role_select_out(role),
    .width_split_select_out(split));

  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: word %h, want %h", $time, got, exp);
    end
  endtask : cmp16

  task automatic cmp3(input logic [2:0] got, input logic [2:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: ctrl %b, want %b", $time, got, exp);
    end
  endtask : cmp3

  // watcher: read data one cycle after the strobe, start pulses any time
  always @(posedge mclk_in) begin
    rd_d <= req.rd;
    if (rd_d) cmp16(rdata, rq.pop_front());
    if (ctrl.start === 1'b1) begin
      if (sq.size() == 0) begin
        fails++;
        $display("wrong value at %0t: stray start", $time);
      end else begin
        cmp3({ctrl.start_irq, ctrl.out_toggle, ctrl.count_up},
             sq.pop_front());
      end
    end
    // capture pulses are noted separately from starts
    if (ctrl.capture === 1'b1) begin
      if (cq.size() == 0) begin
        fails++;
        $display("wrong value at %0t: stray capture", $time);
      end else begin
        cmp3({ctrl.capture, ctrl.counting, ctrl.count_up},
             cq.pop_front());
      end
    end
  end

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_in);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    rq.push_back(e);
    @(posedge mclk_in);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_in);
    req.rd <= 1'b0;
  endtask : rd

  // one-cycle pulse on {flip, m_irq, stop, sw_start}
  task automatic kick(input logic [3:0] k);
    @(posedge mclk_in);
    {flip, m_irq, stop, sw_start} <= k;
    @(posedge mclk_in);
    {flip, m_irq, stop, sw_start} <= 4'h0;
  endtask : kick

  // bounded wait for all notes to be met, then a quiet spell
  task automatic settle();
    int n = 0;
    while ((rq.size() + sq.size() + cq.size()) != 0 && n < 40) begin
      @(posedge mclk_in);
      n++;
    end
    if ((rq.size() + sq.size() + cq.size()) != 0) begin
      fails++;
      $display("wrong value at %0t: result never came", $time);
      conclude();
    end
    repeat (6) @(posedge mclk_in);
  endtask : settle

  initial begin
    logic [15:0] d;
    void'($urandom(57575));
    arst_n_in <= 1'b0; // a real falling edge so the async reset acts
    repeat (8) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    rd(MODE_REG_OFFSET, MODE_RESET);
    settle();
    cmp16({7'h00, ctrl, role, split}, 16'h0000);
    // reserved bits stay zero, bit 11 stores on channel 2
    wr(MODE_REG_OFFSET, 16'hffff);
    rd(MODE_REG_OFFSET, 16'hdfcf);
    settle();
    cmp16({12'h000, opclk, role, split}, 16'h000e);
    repeat (6) begin
      d = 16'($urandom());
      wr(MODE_REG_OFFSET, d);
      rd(MODE_REG_OFFSET, d & MODE_WRITE_MASK);
    end
    rd(4'h9, 16'h0000);
    settle();
    // start per mode, then a busy start
    foreach (modes[i]) begin
      up  = modes[i][3:1] inside {OPM_CAPTURE, OPM_CAPTURE_ONE};
      irq = modes[i][0] && (modes[i][3:1] inside {OPM_INTERVAL, OPM_CAPTURE});
      wr(MODE_REG_OFFSET, {12'h000, modes[i]});
      sq.push_back({irq, irq, up});
      kick(4'h1);
      settle();
      if (!(modes[i][3] && !modes[i][0])) sq.push_back({2'b00, up});
      kick(4'h1);
      settle();
      kick(4'h2); // stop before any rewrite
    end
    // prohibited mode and trigger codes never start
    for (int i = 0; i < 2; i++) begin
      wr(MODE_REG_OFFSET, (i == 0) ? 16'h0002 : 16'h0300);
      kick(4'h1);
      settle();
      rd(STATUS_REG_OFFSET, {12'h000, i == 1, i == 0, pin, 1'b0});
      settle();
    end
    // stop beside start leaves the channel idle
    wr(MODE_REG_OFFSET, 16'h0000);
    kick(4'h3);
    settle();
    rd(STATUS_REG_OFFSET, {14'h0000, pin, 1'b0});
    wr(MODE_REG_OFFSET, 16'h0400);
    sq.push_back(3'b000);
    kick(4'h4);
    settle();
    kick(4'h2);
    // pin edges; edge code 10 for both edges on trigger 001
    foreach (et[i]) begin
      wr(MODE_REG_OFFSET, {5'h00, et[i][4:2], et[i][1:0], 6'h00});
      repeat (2) begin
        // trigger 010 starts only on the start edge of the width code
        if ((et[i][1] && !et[i][3]) || et[i][0] == !pin)
          sq.push_back(3'b000);
        kick(4'h8);
        settle();
      end
      kick(4'h2);
    end
    // capture mode, high width: rise starts, fall captures
    wr(MODE_REG_OFFSET, 16'h12c4);
    sq.push_back(3'b001);
    kick(4'h8);
    settle();
    cq.push_back(3'b111);
    kick(4'h8);
    settle();
    kick(4'h2);
    // second reset in mid-run clears the register
    wr(MODE_REG_OFFSET, 16'h4321);
    @(posedge mclk_in);
    arst_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    rd(MODE_REG_OFFSET, MODE_RESET);
    settle();
    conclude();
  end
endmodule : tb_timer_channel_mode_control
